// File: design/cadj_register_bank.sv
// colour adjustment register bank with its pixel adjust stage
// assumes frameStart and pixels come from logic on clk_sys
// and a host port that never overlaps read and write strobes
//
// Chosen here: the address-and-strobe port.

// Operation
// - fields decode as byte offsets from one shared base address
// - each hue or saturation setting is one read and write byte
// - status bytes read 0x01 for present valid adjustments, else 0x00
// - saturation acts only on pixels predominantly of its own colour
// - saturation 64 leaves the colour unchanged
// - saturation below 64 shrinks it in proportion, 32 halves
// - saturation above 64 grows it in proportion, 128 doubles
// - saturation zero removes the colour entirely
// - hue is a signed byte from -128 to +127 rotating the colour
// - hue zero leaves the colour unchanged
// - hue extremes rotate sixty degrees, fully into the neighbour
// - green hue: negative toward cyan, positive toward yellow
// - cyan hue: negative toward blue, positive toward green
// - blue hue: negative toward magenta, positive toward cyan
// - every setting except magenta saturation reports read-only lower and upper limits
// - every setting except magenta saturation reports a read-only step size
module cadj_register_bank
	import cadj_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	input  wire logic       frameStart,
	input  wire logic       pixValid,
	input  wire logic [7:0] pixRed,
	input  wire logic [7:0] pixGreen,
	input  wire logic [7:0] pixBlue,
	output logic            outValid,
	output logic      [7:0] outRed,
	output logic      [7:0] outGreen,
	output logic      [7:0] outBlue
);

	// address lies in the colour adjustment page
	function automatic logic inPage(input logic [15:0] a);
		return a[15:8] == CADJ_BASE[15:8];
	endfunction

	// writable slot behind an offset
	function automatic logic [2:0] setIndex(input logic [7:0] ofs);
		case (ofs)
			OFS_HUE_GREEN_SET: setIndex = 3'(IDX_HUE_GREEN);
			OFS_SAT_CYAN_SET:  setIndex = 3'(IDX_SAT_CYAN);
			OFS_HUE_CYAN_SET:  setIndex = 3'(IDX_HUE_CYAN);
			OFS_SAT_BLUE_SET:  setIndex = 3'(IDX_SAT_BLUE);
			OFS_HUE_BLUE_SET:  setIndex = 3'(IDX_HUE_BLUE);
			OFS_SAT_MAG_SET:   setIndex = 3'(IDX_SAT_MAG);
			default:           setIndex = IDX_NONE;
		endcase
	endfunction

	function automatic logic [7:0] max3(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] c
	);
		logic [7:0] m;
		m = (a >= b) ? a : b;
		return (m >= c) ? m : c;
	endfunction

	function automatic logic [7:0] min3(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] c
	);
		logic [7:0] m;
		m = (a <= b) ? a : b;
		return (m <= c) ? m : c;
	endfunction

	function automatic logic [7:0] mid3(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] c
	);
		if (a >= b) begin
			mid3 = (b >= c) ? b : ((a >= c) ? c : a);
		end else begin
			mid3 = (a >= c) ? a : ((b >= c) ? c : b);
		end
	endfunction

	// nearest of the six hexagon corners
	function automatic cadj_color_type classify(
		input logic [7:0] r,
		input logic [7:0] g,
		input logic [7:0] b
	);
		logic [7:0] mx;
		logic [7:0] mn;
		logic [7:0] md;
		logic       sec;
		mx = max3(r, g, b);
		mn = min3(r, g, b);
		md = mid3(r, g, b);
		// secondary once the middle channel passes half the chroma
		sec = {md - mn, 1'b0} > {1'b0, mx - mn};
		if (mx == mn) begin
			classify = COL_NONE;
		end else if (r == mx) begin
			classify = sec ? ((g >= b) ? COL_YELLOW : COL_MAGENTA)
				: COL_RED;
		end else if (g == mx) begin
			classify = sec ? ((r >= b) ? COL_YELLOW : COL_CYAN)
				: COL_GREEN;
		end else begin
			classify = sec ? ((r >= g) ? COL_MAGENTA : COL_CYAN)
				: COL_BLUE;
		end
	endfunction

	// chroma above the floor scaled by s/64, 64 is unity
	function automatic logic [7:0] satScale(
		input logic [7:0] c,
		input logic [7:0] mn,
		input logic [7:0] s
	);
		logic [15:0] p;
		logic [10:0] v;
		p = {8'h00, c - mn} * {8'h00, s};
		v = {1'b0, p[15:6]} + {3'h0, mn};
		// doubling a strong colour clips at full scale
		return (v > 11'h0ff) ? 8'hff : v[7:0];
	endfunction

	// share of the chroma moved by a signed hue byte
	function automatic logic [7:0] hueAmt(
		input logic [7:0] chroma,
		input logic [7:0] h
	);
		logic [7:0]  f;
		logic [15:0] p;
		if (h[7]) begin
			f = 8'(~h + 8'h01);
		end else if (h == 8'h00) begin
			f = 8'h00;
		end else begin
			f = h + 8'h01;
		end
		// f of 128 moves the whole chroma, a full sixty degrees
		p = {8'h00, chroma} * {8'h00, f};
		return p[14:7];
	endfunction

	function automatic logic [7:0] raise(
		input logic [7:0] ch,
		input logic [7:0] amt,
		input logic [7:0] mx
	);
		logic [8:0] s;
		s = {1'b0, ch} + {1'b0, amt};
		return (s > {1'b0, mx}) ? mx : s[7:0];
	endfunction

	function automatic logic [7:0] lower(
		input logic [7:0] ch,
		input logic [7:0] amt,
		input logic [7:0] mn
	);
		logic [8:0] d;
		d = {1'b0, ch} - {1'b0, amt};
		return (d[8] || d[7:0] < mn) ? mn : d[7:0];
	endfunction

	logic [7:0]     setShadow_q [CADJ_NSET];
	logic [7:0]     setActive_q [CADJ_NSET];
	logic [7:0]     setEff [CADJ_NSET];
	logic [2:0]     wrIdx;
	logic           wrHit;
	logic [7:0]     rdMux;
	cadj_color_type pixClass;
	logic [7:0]     floor0;
	logic [7:0]     satSel;
	logic           doSat;
	logic [7:0]     satR;
	logic [7:0]     satG;
	logic [7:0]     satB;
	logic [7:0]     top1;
	logic [7:0]     floor1;
	logic [7:0]     hueSel;
	logic [7:0]     amt;
	logic [7:0]     adjRed_d;
	logic [7:0]     adjGreen_d;
	logic [7:0]     adjBlue_d;
	logic           outValid_q;
	logic [7:0]     outRed_q;
	logic [7:0]     outGreen_q;
	logic [7:0]     outBlue_q;
	logic [7:0]     regRdData_q;

	// host write decode
	assign wrIdx = setIndex(regAddr[7:0]);
	assign wrHit = regWrite && inPage(regAddr) && wrIdx != IDX_NONE;

	// shadow takes writes, active copy follows at frame start
	for (genvar i = 0; i < CADJ_NSET; i++) begin : gSet
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				setShadow_q[i] <= SET_RESET[i];
			end else if (wrHit && wrIdx == 3'(i)) begin
				setShadow_q[i] <= regWrData;
			end
		end

		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				setActive_q[i] <= SET_RESET[i];
			end else if (frameStart) begin
				setActive_q[i] <= setShadow_q[i];
			end
		end

		// the frame's first pixel already sees the new values
		assign setEff[i] = frameStart ? setShadow_q[i]
			: setActive_q[i];
	end

	// read multiplexer over the page
	always_comb begin
		rdMux = 8'h00;
		if (inPage(regAddr)) begin
			case (regAddr[7:0])
				OFS_HUE_GREEN_STATE, OFS_SAT_CYAN_STATE,
				OFS_HUE_CYAN_STATE, OFS_SAT_BLUE_STATE,
				OFS_HUE_BLUE_STATE, OFS_SAT_MAG_STATE: begin
					rdMux = STATE_OK;
				end
				OFS_SAT_CYAN_LOW, OFS_SAT_BLUE_LOW: begin
					rdMux = SAT_LOW;
				end
				OFS_SAT_CYAN_UP, OFS_SAT_BLUE_UP: begin
					rdMux = SAT_UP;
				end
				OFS_HUE_GREEN_LOW, OFS_HUE_CYAN_LOW,
				OFS_HUE_BLUE_LOW: begin
					rdMux = HUE_LOW;
				end
				OFS_HUE_GREEN_UP, OFS_HUE_CYAN_UP,
				OFS_HUE_BLUE_UP: begin
					rdMux = HUE_UP;
				end
				OFS_SAT_GREEN_STEP, OFS_SAT_CYAN_STEP,
				OFS_SAT_BLUE_STEP: begin
					rdMux = SAT_STEP;
				end
				OFS_HUE_GREEN_STEP, OFS_HUE_CYAN_STEP,
				OFS_HUE_BLUE_STEP: begin
					rdMux = HUE_STEP;
				end
				default: begin
					// settings read back what software last wrote
					if (wrIdx != IDX_NONE) begin
						rdMux = setShadow_q[wrIdx];
					end else begin
						rdMux = STATE_ABSENT;
					end
				end
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			regRdData_q <= 8'h00;
		end else if (regRead) begin
			regRdData_q <= rdMux;
		end else begin
			regRdData_q <= 8'h00;
		end
	end

	// saturation stage, only for the pixel's own colour
	always_comb begin
		pixClass = classify(pixRed, pixGreen, pixBlue);
		floor0 = min3(pixRed, pixGreen, pixBlue);
		satSel = SAT_RESET;
		doSat = 1'b0;
		case (pixClass)
			COL_CYAN: begin
				satSel = setEff[IDX_SAT_CYAN];
				doSat = 1'b1;
			end
			COL_BLUE: begin
				satSel = setEff[IDX_SAT_BLUE];
				doSat = 1'b1;
			end
			COL_MAGENTA: begin
				satSel = setEff[IDX_SAT_MAG];
				doSat = 1'b1;
			end
			default: begin
				doSat = 1'b0;
			end
		endcase
		satR = doSat ? satScale(pixRed, floor0, satSel) : pixRed;
		satG = doSat ? satScale(pixGreen, floor0, satSel) : pixGreen;
		satB = doSat ? satScale(pixBlue, floor0, satSel) : pixBlue;
	end

	// hue stage moves the chroma share toward the neighbour
	always_comb begin
		top1 = max3(satR, satG, satB);
		floor1 = min3(satR, satG, satB);
		case (pixClass)
			COL_GREEN: hueSel = setEff[IDX_HUE_GREEN];
			COL_CYAN:  hueSel = setEff[IDX_HUE_CYAN];
			COL_BLUE:  hueSel = setEff[IDX_HUE_BLUE];
			default:   hueSel = HUE_RESET;
		endcase
		amt = hueAmt(top1 - floor1, hueSel);
		adjRed_d = satR;
		adjGreen_d = satG;
		adjBlue_d = satB;
		case (pixClass)
			COL_GREEN: begin
				if (hueSel[7]) begin
					adjBlue_d = raise(satB, amt, top1);
				end else begin
					adjRed_d = raise(satR, amt, top1);
				end
			end
			COL_CYAN: begin
				if (hueSel[7]) begin
					adjGreen_d = lower(satG, amt, floor1);
				end else begin
					adjBlue_d = lower(satB, amt, floor1);
				end
			end
			COL_BLUE: begin
				if (hueSel[7]) begin
					adjRed_d = raise(satR, amt, top1);
				end else begin
					adjGreen_d = raise(satG, amt, top1);
				end
			end
			default: begin
				adjRed_d = satR;
			end
		endcase
	end

	// output pixel register, one cycle of latency
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			outValid_q <= 1'b0;
		end else begin
			outValid_q <= pixValid;
		end
	end

	// data held between valid pixels
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			outRed_q <= 8'h00;
			outGreen_q <= 8'h00;
			outBlue_q <= 8'h00;
		end else if (pixValid) begin
			outRed_q <= adjRed_d;
			outGreen_q <= adjGreen_d;
			outBlue_q <= adjBlue_d;
		end
	end

	assign regRdData = regRdData_q;
	assign outValid = outValid_q;
	assign outRed = outRed_q;
	assign outGreen = outGreen_q;
	assign outBlue = outBlue_q;

endmodule // cadj_register_bank

// File: design/cadj_pkg.sv
// constants of the colour adjustment register bank
// assumes a byte-wide host register port on the system clock
package cadj_pkg;

	// register page shared by the whole colour adjustment group
	localparam logic [15:0] CADJ_BASE = 16'h4400;

	// byte offsets from the base
	localparam logic [7:0] OFS_SAT_GREEN_STEP  = 8'h1d;
	localparam logic [7:0] OFS_HUE_GREEN_STATE = 8'h1e;
	localparam logic [7:0] OFS_HUE_GREEN_SET   = 8'h1f;
	localparam logic [7:0] OFS_HUE_GREEN_LOW   = 8'h20;
	localparam logic [7:0] OFS_HUE_GREEN_UP    = 8'h21;
	localparam logic [7:0] OFS_HUE_GREEN_STEP  = 8'h22;
	localparam logic [7:0] OFS_SAT_CYAN_STATE  = 8'h23;
	localparam logic [7:0] OFS_SAT_CYAN_SET    = 8'h24;
	localparam logic [7:0] OFS_SAT_CYAN_LOW    = 8'h25;
	localparam logic [7:0] OFS_SAT_CYAN_UP     = 8'h26;
	localparam logic [7:0] OFS_SAT_CYAN_STEP   = 8'h27;
	localparam logic [7:0] OFS_HUE_CYAN_STATE  = 8'h28;
	localparam logic [7:0] OFS_HUE_CYAN_SET    = 8'h29;
	localparam logic [7:0] OFS_HUE_CYAN_LOW    = 8'h2a;
	localparam logic [7:0] OFS_HUE_CYAN_UP     = 8'h2b;
	localparam logic [7:0] OFS_HUE_CYAN_STEP   = 8'h2c;
	localparam logic [7:0] OFS_SAT_BLUE_STATE  = 8'h2d;
	localparam logic [7:0] OFS_SAT_BLUE_SET    = 8'h2e;
	localparam logic [7:0] OFS_SAT_BLUE_LOW    = 8'h2f;
	localparam logic [7:0] OFS_SAT_BLUE_UP     = 8'h30;
	localparam logic [7:0] OFS_SAT_BLUE_STEP   = 8'h31;
	localparam logic [7:0] OFS_HUE_BLUE_STATE  = 8'h32;
	localparam logic [7:0] OFS_HUE_BLUE_SET    = 8'h33;
	localparam logic [7:0] OFS_HUE_BLUE_LOW    = 8'h34;
	localparam logic [7:0] OFS_HUE_BLUE_UP     = 8'h35;
	localparam logic [7:0] OFS_HUE_BLUE_STEP   = 8'h36;
	localparam logic [7:0] OFS_SAT_MAG_STATE   = 8'h37;
	localparam logic [7:0] OFS_SAT_MAG_SET     = 8'h38;

	// status byte codes
	localparam logic [7:0] STATE_ABSENT = 8'h00;
	localparam logic [7:0] STATE_OK     = 8'h01;

	// limits and steps reported to software
	localparam logic [7:0] SAT_LOW  = 8'h00;
	localparam logic [7:0] SAT_UP   = 8'hff;
	localparam logic [7:0] SAT_STEP = 8'h01;
	localparam logic [7:0] HUE_LOW  = 8'h80;
	localparam logic [7:0] HUE_UP   = 8'h7f;
	localparam logic [7:0] HUE_STEP = 8'h01;

	// reset values: unity saturation, no hue rotation
	localparam logic [7:0] SAT_RESET = 8'h40;
	localparam logic [7:0] HUE_RESET = 8'h00;

	// storage slots of the writable settings
	localparam int CADJ_NSET     = 6;
	localparam int IDX_HUE_GREEN = 0;
	localparam int IDX_SAT_CYAN  = 1;
	localparam int IDX_HUE_CYAN  = 2;
	localparam int IDX_SAT_BLUE  = 3;
	localparam int IDX_HUE_BLUE  = 4;
	localparam int IDX_SAT_MAG   = 5;
	localparam logic [2:0] IDX_NONE = 3'h7;

	localparam logic [7:0] SET_RESET [CADJ_NSET] = '{
		HUE_RESET, SAT_RESET, HUE_RESET,
		SAT_RESET, HUE_RESET, SAT_RESET
	};

	// predominant colour of a pixel
	typedef enum logic [6:0] {
		COL_NONE    = 7'h01,
		COL_RED     = 7'h02,
		COL_YELLOW  = 7'h04,
		COL_GREEN   = 7'h08,
		COL_CYAN    = 7'h10,
		COL_BLUE    = 7'h20,
		COL_MAGENTA = 7'h40
	} cadj_color_type;

endpackage

// File: verif/cadj_register_bank_asserts.sv
// concurrent checks on the colour adjustment register bank ports
// assumes one clock, clk_sys, and the active high async reset
module cadj_register_bank_asserts
	import cadj_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [15:0] regAddr,
	input wire logic [7:0]  regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [7:0]  regRdData,
	input wire logic        frameStart,
	input wire logic        pixValid,
	input wire logic [7:0]  pixRed,
	input wire logic [7:0]  pixGreen,
	input wire logic [7:0]  pixBlue,
	input wire logic        outValid,
	input wire logic [7:0]  outRed,
	input wire logic [7:0]  outGreen,
	input wire logic [7:0]  outBlue
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// host port: decode, idle level and fixed bytes
	a_page_decode: assert property ( // other pages
		regRead && regAddr[15:8] != 8'h44 |=> regRdData == 8'h00)
		else $error("read outside the page returned data");
	a_idle_zero: assert property ( // byte port
		!regRead |=> regRdData == 8'h00)
		else $error("read data seen without a read strobe");
	a_status_ok: assert property ( // status bytes
		regRead && regAddr inside {16'h441e, 16'h4423, 16'h4428,
		16'h442d, 16'h4432, 16'h4437} |=> regRdData == STATE_OK)
		else $error("status byte did not read one");
	a_hue_lower: assert property ( // hue lower limits
		regRead && regAddr inside {16'h4420, 16'h442a, 16'h4434}
		|=> regRdData == 8'h80)
		else $error("hue lower limit wrong");
	a_step_bytes: assert property ( // step bytes
		regRead && regAddr inside {16'h441d, 16'h4422, 16'h4427,
		16'h442c, 16'h4431, 16'h4436} |=> regRdData == 8'h01)
		else $error("step byte did not read one");
	a_write_readback: assert property ( // readback
		regWrite && regAddr == 16'h4424 ##1 regRead && regAddr == 16'h4424
		|=> regRdData == $past(regWrData, 2))
		else $error("written setting not read back");
	// pixels of no adjusted colour pass one cycle later untouched
	a_gray_pass: assert property ( // no colour
		pixValid && pixRed == pixGreen && pixGreen == pixBlue |=> outValid
		&& {outRed, outGreen, outBlue} == $past({pixRed, pixGreen, pixBlue}))
		else $error("gray pixel was altered");
	a_red_pass: assert property ( // other colour
		pixValid && pixRed > pixGreen && pixGreen == pixBlue |=> outValid
		&& {outRed, outGreen, outBlue} == $past({pixRed, pixGreen, pixBlue}))
		else $error("red pixel was altered");
endmodule // cadj_register_bank_asserts

bind cadj_register_bank cadj_register_bank_asserts cadj_asserts_inst (
	.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
	.regRdData(regRdData), .frameStart(frameStart), .pixValid(pixValid),
	.pixRed(pixRed), .pixGreen(pixGreen), .pixBlue(pixBlue),
	.outValid(outValid), .outRed(outRed), .outGreen(outGreen),
	.outBlue(outBlue));

// File: verif/cadj_register_bank_tb.sv
// self-checking bench of the colour adjustment register bank
// assumes cadj_pkg and the bank compiled first, checker bound
module cadj_register_bank_tb
	import cadj_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0]  regWrData = 8'h00;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [7:0]  regRdData;
	logic        frameStart = 1'b0;
	logic        pixValid = 1'b0;
	logic [7:0]  pixRed = 8'h00;
	logic [7:0]  pixGreen = 8'h00;
	logic [7:0]  pixBlue = 8'h00;
	logic        outValid;
	logic [7:0]  outRed;
	logic [7:0]  outGreen;
	logic [7:0]  outBlue;
	int          failures = 0;
	int          total_checks = 0;
	logic [31:0] seed = 32'h1723;

	cadj_register_bank cadj_register_bank_inst (
		.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .frameStart(frameStart),
		.pixValid(pixValid), .pixRed(pixRed), .pixGreen(pixGreen),
		.pixBlue(pixBlue), .outValid(outValid), .outRed(outRed),
		.outGreen(outGreen), .outBlue(outBlue));

	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;

	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// reset content of every byte of the page
	function automatic logic [7:0] rexp(input logic [7:0] o);
		case (o)
			8'h1d, 8'h1e, 8'h22, 8'h23, 8'h27, 8'h28, 8'h2c, 8'h2d,
			8'h31, 8'h32, 8'h36, 8'h37: return 8'h01;
			8'h20, 8'h2a, 8'h34: return 8'h80;
			8'h21, 8'h2b, 8'h35: return 8'h7f;
			8'h26, 8'h30: return 8'hff;
			8'h24, 8'h2e, 8'h38: return 8'h40;
			default: return 8'h00;
		endcase
	endfunction

	function automatic bit isRw(input logic [7:0] o);
		return o inside {8'h1f, 8'h24, 8'h29, 8'h2e, 8'h33, 8'h38};
	endfunction

	// gain of 64 is unity, clipped at full scale
	function automatic logic [7:0] satf(input int c, input int mn, input int s);
		int v;
		v = mn + (((c - mn) * s) >>> 6);
		return (v > 255) ? 8'hff : v[7:0];
	endfunction

	task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	task rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 chk8("regRdData", exp, regRdData);
	endtask

	// write and read back with no gap between the strobes
	task wrrd(input logic [7:0] o, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= {8'h44, o};
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 chk8("readback", exp, regRdData);
	endtask

	// settings become active only on this pulse
	task frame();
		@(posedge clk_sys);
		frameStart <= 1'b1;
		@(posedge clk_sys);
		frameStart <= 1'b0;
	endtask

	task px(input logic [7:0] r, g, b, er, eg, eb);
		@(posedge clk_sys);
		pixValid <= 1'b1;
		pixRed <= r;
		pixGreen <= g;
		pixBlue <= b;
		@(posedge clk_sys);
		pixValid <= 1'b0;
		#1 chk8("outValid", 8'h01, {7'h00, outValid});
		chk8("outRed", er, outRed);
		chk8("outGreen", eg, outGreen);
		chk8("outBlue", eb, outBlue);
	endtask

	task hue(input logic [7:0] o, h, r, g, b, er, eg, eb);
		wr({8'h44, o}, h);
		frame();
		px(r, g, b, er, eg, eb);
		wr({8'h44, o}, 8'h00);
		frame();
	endtask

	initial begin
		logic [7:0] d;
		logic [7:0] s;
		logic [7:0] sats [4];
		sats = '{8'h40, 8'h20, 8'h80, 8'h00};
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		for (int o = 'h1c; o <= 'h39; o++) begin
			rd({8'h44, o[7:0]}, rexp(o[7:0])); // reset bytes
		end
		for (int o = 'h1c; o <= 'h39; o++) begin
			d = rnd();
			wrrd(o[7:0], d, isRw(o[7:0]) ? d : rexp(o[7:0]));
		end
		wr(16'h4524, 8'h77);
		rd(16'h4524, 8'h00); // foreign page
		for (int o = 'h1f; o <= 'h38; o++) begin
			if (isRw(o[7:0])) wr({8'h44, o[7:0]}, rexp(o[7:0]));
		end
		frame();
		// gray and red pixels pass untouched at the reset settings
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			s = rnd();
			px(d, d, d, d, d, d); // no colour
			px({1'b1, s[6:0]}, d >> 1, d >> 1,
				{1'b1, s[6:0]}, d >> 1, d >> 1); // red
		end
		// table of corner gains, then a random one
		for (int i = 0; i < 5; i++) begin
			s = (i < 4) ? sats[i] : rnd();
			wr(16'h4424, s);
			wr(16'h442e, s);
			wr(16'h4438, s);
			frame();
			px(20, 120, 120, 20, satf(120, 20, s), satf(120, 20, s));
			px(10, 10, 110, 10, 10, satf(110, 10, s)); // blue gain
			px(110, 10, 110, satf(110, 10, s), 10, satf(110, 10, s));
		end
		// a write without a frame pulse must not change the output yet
		wr(16'h4424, 8'h20);
		px(20, 120, 120, 20, satf(120, 20, s), satf(120, 20, s));
		frame();
		px(20, 120, 120, 20, 70, 70); // halved after the frame
		wr(16'h4424, 8'h40);
		wr(16'h442e, 8'h40);
		wr(16'h4438, 8'h40);
		frame();
		hue(8'h1f, 8'h80, 0, 200, 0, 0, 200, 200); // green to cyan
		hue(8'h1f, 8'h7f, 0, 200, 0, 200, 200, 0);
		hue(8'h1f, 8'hc0, 0, 200, 0, 0, 200, 100); // halfway to cyan
		hue(8'h29, 8'h80, 0, 200, 200, 0, 0, 200); // cyan to blue
		hue(8'h29, 8'h7f, 0, 200, 200, 0, 200, 0);
		hue(8'h33, 8'h80, 0, 0, 200, 200, 0, 200); // blue to magenta
		hue(8'h33, 8'h7f, 0, 0, 200, 0, 200, 200);
		px(0, 200, 0, 0, 200, 0); // zero rotation
		finish_test();
	end

	// cut a hang well past the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		finish_test();
	end
endmodule // cadj_register_bank_tb
